// [design/ascs_pkg.sv]
// Package for the start-up configuration block: register map, fields, resets, timing.
// Assumes an APB slave with 32-bit data and a single 40 MHz clock.
package ascs_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [11:0] ADDR_CTRL = 12'h004;
    localparam logic [11:0] ADDR_LINK_CFG = 12'h008;
    localparam logic [11:0] ADDR_CAL_CFG = 12'h00C;
    localparam logic [11:0] ADDR_TRIG = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_TAP_CENTER = 12'h018;
    localparam logic [11:0] ADDR_TAP_NINE = 12'h01C;
    // ==========================================================
    // Field positions and widths
    localparam int CTRL_LINK_EN_BIT = 0;
    localparam int CTRL_CAL_EN_BIT = 1;
    localparam int CTRL_OVERRANGE_ENABLE_BIT = 2;
    localparam int LINK_MODE_LSB = 0;
    localparam int LINK_MODE_W = 5;
    localparam int KM1_LSB = 8;
    localparam int KM1_W = 8;
    localparam int SYNC_SEL_BIT = 16;
    localparam int CAL_BG_BIT = 0;
    localparam int CAL_OFS_BIT = 1;
    localparam int TAP_W = 12;
    localparam int TAP_CENTER_W = 18;
    // ==========================================================
    // Reset values and timing
    localparam logic [LINK_MODE_W-1:0] LINK_MODE_RST = 5'h00;
    localparam logic [KM1_W-1:0] KM1_RST = 8'h1F;
    localparam logic [TAP_W-1:0] TAP_RST = 12'h000;
    localparam logic [TAP_CENTER_W-1:0] TAP_CENTER_RST = 18'h00000;
    localparam int CLK_MHZ = 40;
    localparam int SOFT_RESET_NS = 1000;
    localparam int SOFT_RESET_CYC = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int CAL_RUN_CYC = 64;
    localparam int CNT_W = 8;

    typedef enum logic [1:0] {LNK_HALT, LNK_WAIT_SYNC, LNK_DATA} ascs_link_t;
    typedef enum logic [1:0] {CAL_HALT, CAL_IDLE, CAL_RUN} ascs_cal_t;

    // Settings that travel together to the datapath
    typedef struct packed {
        logic [LINK_MODE_W-1:0] link_mode;
        logic [KM1_W-1:0] km1;
        logic sync_sel;
        logic cal_bg;
        logic cal_ofs;
        logic overrange_enable;
    } ascs_cfg_t;

    typedef struct packed {
        logic link_en;
        logic cal_en;
        logic trig;
        ascs_cfg_t cfg;
        logic [TAP_W-1:0] tap_nine;
        logic [TAP_CENTER_W-1:0] tap_center;
        ascs_link_t link_st;
        ascs_cal_t cal_st;
        logic [CNT_W-1:0] cal_cnt;
        logic [CNT_W-1:0] rst_cnt;
        logic cal_done;
        logic link_run;
        logic link_data;
        logic cal_run;
        logic [2:0] sync_sh;
        logic sync_req;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ascs_state_t;
endpackage : ascs_pkg

// [design/ascs_top.sv]
// Configuration and start-up sequencing registers with link and calibration engines.
// Assumes an APB master on pclk and a receiver sync request arriving asynchronously.
`timescale 1ns/1ps
module ascs_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Receiver sync request, active low
    input wire logic sync_req_n,
    // Engine state and settings toward the datapath
    output logic link_running,
    output logic link_data_valid,
    output logic cal_running,
    output ascs_pkg::ascs_cfg_t cfg_out,
    output logic [ascs_pkg::TAP_W-1:0] tap_nine_out,
    output logic [ascs_pkg::TAP_CENTER_W-1:0] tap_center_out
);
    ascs_pkg::ascs_state_t q, d;
    logic wr, rd;

    // ==========================================================
    // Bus decode; one wait state in each access phase
    assign wr = psel && penable && pwrite && !q.pready;
    assign rd = psel && penable && !pwrite && !q.pready;

    // ==========================================================
    // Next-state logic
    // Both engines read only registered enables, so a write that clears an
    // enable halts its engine on the following cycle, never mid-decode.
    // Settings are held in flops and not gated by the enables: the host is
    // trusted to change them only while the matching engine is stopped.
    always_comb begin
        d = q;
        d.pready = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        d.sync_sh = {q.sync_sh[1:0], ~sync_req_n};
        // Second and third stage agree before the level is believed
        if (q.sync_sh[2] == q.sync_sh[1]) begin
            d.sync_req = q.sync_sh[2];
        end
        if (q.rst_cnt != '0) begin
            d.rst_cnt = q.rst_cnt - 1'b1;
        end
        if (wr) begin
            case (paddr)
                ascs_pkg::ADDR_RESET: begin
                    // Soft reset back to defaults, host then waits
                    if (pwdata[0]) begin
                        d.link_en = 1'b0;
                        d.cal_en = 1'b0;
                        d.trig = 1'b0;
                        d.cfg = '{ascs_pkg::LINK_MODE_RST, ascs_pkg::KM1_RST, 1'b0, 1'b0, 1'b0,
                                  1'b0};
                        d.tap_nine = ascs_pkg::TAP_RST;
                        d.tap_center = ascs_pkg::TAP_CENTER_RST;
                        d.rst_cnt = CNT_W_ONE(ascs_pkg::SOFT_RESET_CYC);
                    end
                end
                ascs_pkg::ADDR_CTRL: begin
                    d.link_en = pwdata[ascs_pkg::CTRL_LINK_EN_BIT];
                    d.cal_en = pwdata[ascs_pkg::CTRL_CAL_EN_BIT];
                    d.cfg.overrange_enable = pwdata[ascs_pkg::CTRL_OVERRANGE_ENABLE_BIT];
                end
                ascs_pkg::ADDR_LINK_CFG: begin
                    // Stored only; reaches cfg_out on the next cycle, the link engine never reads it
                    d.cfg.link_mode = pwdata[ascs_pkg::LINK_MODE_LSB +: ascs_pkg::LINK_MODE_W];
                    d.cfg.km1 = pwdata[ascs_pkg::KM1_LSB +: ascs_pkg::KM1_W];
                    d.cfg.sync_sel = pwdata[ascs_pkg::SYNC_SEL_BIT];
                end
                ascs_pkg::ADDR_CAL_CFG: begin
                    d.cfg.cal_bg = pwdata[ascs_pkg::CAL_BG_BIT];
                    d.cfg.cal_ofs = pwdata[ascs_pkg::CAL_OFS_BIT];
                end
                ascs_pkg::ADDR_TRIG: begin
                    d.trig = pwdata[0];
                end
                ascs_pkg::ADDR_TAP_CENTER: begin
                    d.tap_center = pwdata[ascs_pkg::TAP_CENTER_W-1:0];
                end
                ascs_pkg::ADDR_TAP_NINE: begin
                    d.tap_nine = pwdata[ascs_pkg::TAP_W-1:0];
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end
        // Link engine; disabled means halted in every state
        case (q.link_st)
            ascs_pkg::LNK_HALT: begin
                if (q.link_en) begin
                    d.link_st = ascs_pkg::LNK_WAIT_SYNC;
                end
            end
            ascs_pkg::LNK_WAIT_SYNC: begin
                if (q.sync_req == 1'b0) begin
                    d.link_st = ascs_pkg::LNK_DATA;
                end
            end
            ascs_pkg::LNK_DATA: begin
                // Receiver asserting sync again forces realignment
                if (q.sync_req) begin
                    d.link_st = ascs_pkg::LNK_WAIT_SYNC;
                end
            end
            default: begin
                d.link_st = ascs_pkg::LNK_HALT;
            end
        endcase
        if (!q.link_en) begin
            d.link_st = ascs_pkg::LNK_HALT;
        end
        // Calibration engine; rising trigger starts a run
        case (q.cal_st)
            ascs_pkg::CAL_HALT: begin
                if (q.cal_en) begin
                    d.cal_st = ascs_pkg::CAL_IDLE;
                end
            end
            ascs_pkg::CAL_IDLE: begin
                if (d.trig && !q.trig) begin
                    d.cal_st = ascs_pkg::CAL_RUN;
                    d.cal_cnt = CNT_W_ONE(ascs_pkg::CAL_RUN_CYC);
                    d.cal_done = 1'b0;
                end
            end
            ascs_pkg::CAL_RUN: begin
                if (q.cal_cnt == CNT_W_ONE(1)) begin
                    d.cal_st = ascs_pkg::CAL_IDLE;
                    d.cal_done = 1'b1;
                end
                d.cal_cnt = q.cal_cnt - 1'b1;
            end
            default: begin
                d.cal_st = ascs_pkg::CAL_HALT;
            end
        endcase
        if (!q.cal_en) begin
            d.cal_st = ascs_pkg::CAL_HALT;
        end
        // Engine status decoded from the next state so the pins come from flops
        d.link_run = d.link_st != ascs_pkg::LNK_HALT;
        d.link_data = d.link_st == ascs_pkg::LNK_DATA;
        d.cal_run = d.cal_st == ascs_pkg::CAL_RUN;
        // Read path; reserved bits read zero
        if (rd) begin
            case (paddr)
                ascs_pkg::ADDR_RESET: d.prdata = {31'h0, q.rst_cnt != '0};
                ascs_pkg::ADDR_CTRL: d.prdata = {29'h0, q.cfg.overrange_enable, q.cal_en, q.link_en};
                ascs_pkg::ADDR_LINK_CFG: d.prdata = {15'h0, q.cfg.sync_sel, q.cfg.km1,
                                                     3'h0, q.cfg.link_mode};
                ascs_pkg::ADDR_CAL_CFG: d.prdata = {30'h0, q.cfg.cal_ofs, q.cfg.cal_bg};
                ascs_pkg::ADDR_TRIG: d.prdata = {31'h0, q.trig};
                ascs_pkg::ADDR_STATUS: d.prdata = {26'h0, q.cal_done, q.sync_req,
                                                   q.cal_st, q.link_st};
                ascs_pkg::ADDR_TAP_CENTER: d.prdata = {14'h0, q.tap_center};
                ascs_pkg::ADDR_TAP_NINE: d.prdata = {20'h0, q.tap_nine};
                default: begin
                    d.prdata = 32'h0000_0000;
                    d.pslverr = 1'b1;
                end
            endcase
        end
    end

    // Narrow an integer count to the counter width
    function automatic logic [ascs_pkg::CNT_W-1:0] CNT_W_ONE(input int n);
        CNT_W_ONE = n[ascs_pkg::CNT_W-1:0];
    endfunction : CNT_W_ONE

    // ==========================================================
    // State register; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.cfg.km1 <= ascs_pkg::KM1_RST;
            q.link_st <= ascs_pkg::LNK_HALT;
            q.cal_st <= ascs_pkg::CAL_HALT;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign link_running = q.link_run;
    assign link_data_valid = q.link_data;
    assign cal_running = q.cal_run;
    assign cfg_out = q.cfg;
    assign tap_nine_out = q.tap_nine;
    assign tap_center_out = q.tap_center;
endmodule : ascs_top

// [tb/ascs_props.sv]
// Checker for the start-up configuration block, bound to its top module.
// Assumes only the APB, engine and tap_nine_out ports of that top.
`timescale 1ns/1ps
module ascs_props (
    // Clock and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Engines and taps
    input wire logic sync_req_n,
    input wire logic link_running,
    input wire logic link_data_valid,
    input wire logic cal_running,
    input wire logic [ascs_pkg::TAP_W-1:0] tap_nine_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] run_cnt_q;
    // ==========================================
    // Run length counter, cleared when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run_cnt_q <= 8'h00;
        else run_cnt_q <= cal_running ? run_cnt_q + 8'h01 : 8'h00;
    end
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no pready");
    ready_qual_a: assert property (pready |-> psel && penable) else $error("stray pready");
    err_qual_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    data_needs_link_a: assert property (link_data_valid |-> link_running)
        else $error("data while halted");
    sync_hold_a: assert property (!sync_req_n [*6] |-> !link_data_valid)
        else $error("data during sync request");
    cal_len_a: assert property (run_cnt_q <= 8'h40) else $error("run too long");
    cal_end_a: assert property ($fell(cal_running) |-> run_cnt_q == 8'h40)
        else $error("run too short");
    tap_write_a: assert property ($changed(tap_nine_out) |->
        $past(psel && penable && pwrite && !pready)) else $error("tap changed alone");
    cover property ($rose(cal_running));
    cover property ($rose(link_data_valid));
    cover property (pslverr);
endmodule : ascs_props
bind ascs_top ascs_props ascs_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .sync_req_n(sync_req_n), .link_running(link_running),
    .link_data_valid(link_data_valid), .cal_running(cal_running),
    .tap_nine_out(tap_nine_out));

// [tb/ascs_rx_model.sv]
// Receiving logic device model: drives the link sync request.
// Assumes the bench grants sync completion; requests again when link halts.
`timescale 1ns/1ps
module ascs_rx_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link status and bench control
    input wire logic link_running,
    input wire logic sync_grant,
    // Sync request, active low
    output logic sync_req_n
);
    // Request held until link runs and alignment is granted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sync_req_n <= 1'b0;
        else sync_req_n <= link_running && sync_grant;
    end
endmodule : ascs_rx_model

// [tb/tb_adc_startup_config_sequence.sv]
// Self-checking bench for the start-up configuration block.
// Assumes the one-wait-state APB slave and receiver model beside it.
`timescale 1ns/1ps
module tb_adc_startup_config_sequence;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, sync_req_n, link_running, link_data_valid, cal_running, e;
    logic sync_grant = 1'b0;
    ascs_pkg::ascs_cfg_t cfg_out;
    logic [ascs_pkg::TAP_W-1:0] tap_nine_out;
    logic [ascs_pkg::TAP_CENTER_W-1:0] tap_center_out;
    int miscompares = 0, num_checks = 0, cycles = 0, n, cal_cycles = 0;
    ascs_top ascs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sync_req_n(sync_req_n), .link_running(link_running),
        .link_data_valid(link_data_valid), .cal_running(cal_running), .cfg_out(cfg_out),
        .tap_nine_out(tap_nine_out), .tap_center_out(tap_center_out));
    ascs_rx_model ascs_rx_model_inst (.pclk(pclk), .presetn(presetn),
        .link_running(link_running), .sync_grant(sync_grant), .sync_req_n(sync_req_n));
    // ==========================================
    // Clock and hang guard
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cal_running === 1'b1) cal_cycles++; // Edges seen inside a run
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            $display("ERROR %s expected %h seen %h", nm, x, g);
            miscompares++;
        end
    endtask : chk
    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 200) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_for
    // ==========================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, ascs_pkg::ADDR_TAP_NINE, 32'h0);
        chk("tap9 reset", 32'h0, r);
        chk("km1 reset", 32'h1F, {24'h0, cfg_out.km1});
        apb(1'b1, ascs_pkg::ADDR_TAP_NINE, 32'hFFFFFFFF);
        apb(1'b0, ascs_pkg::ADDR_TAP_NINE, 32'h0);
        chk("tap9 read", 32'h00000FFF, r);
        chk("tap9 out", 32'h00000FFF, {20'h0, tap_nine_out});
        apb(1'b1, ascs_pkg::ADDR_TAP_CENTER, 32'hFFFFFFFF);
        apb(1'b0, ascs_pkg::ADDR_TAP_CENTER, 32'h0);
        chk("center tap", 32'h0003FFFF, r);
        chk("center out", 32'h0003FFFF, {14'h0, tap_center_out});
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask : t_regs
    // Soft reset returns taps to defaults; busy must clear after the wait
    task automatic t_soft();
        apb(1'b1, ascs_pkg::ADDR_RESET, 32'h1);
        apb(1'b0, ascs_pkg::ADDR_RESET, 32'h0);
        chk("reset busy", 32'h1, r);
        chk("soft tap9", 32'h0, {20'h0, tap_nine_out});
        chk("soft center", 32'h0, {14'h0, tap_center_out});
        chk("soft km1", 32'h1F, {24'h0, cfg_out.km1});
        repeat (ascs_pkg::SOFT_RESET_CYC) @(posedge pclk);
        apb(1'b0, ascs_pkg::ADDR_RESET, 32'h0);
        chk("reset done", 32'h0, r);
    endtask : t_soft
    task automatic t_cfg();
        apb(1'b1, ascs_pkg::ADDR_CTRL, 32'h0);
        chk("link halted", 32'h0, {31'h0, link_running});
        apb(1'b1, ascs_pkg::ADDR_LINK_CFG, 32'h00010F0A);
        apb(1'b1, ascs_pkg::ADDR_CAL_CFG, 32'h00000003);
        apb(1'b0, ascs_pkg::ADDR_LINK_CFG, 32'h0);
        chk("link cfg read", 32'h00010F0A, r);
        chk("cfg", {15'h0, 5'h0A, 8'h0F, 4'b1110}, {15'h0, cfg_out});
    endtask : t_cfg
    task automatic t_cal();
        apb(1'b1, ascs_pkg::ADDR_TRIG, 32'h0);
        apb(1'b1, ascs_pkg::ADDR_TRIG, 32'h1);
        repeat (4) @(posedge pclk);
        chk("cal halted", 32'h0, {31'h0, cal_running});
        apb(1'b1, ascs_pkg::ADDR_CTRL, 32'h6);
        chk("ovr enable", 32'h1, {31'h0, cfg_out.overrange_enable});
        apb(1'b1, ascs_pkg::ADDR_TRIG, 32'h0);
        apb(1'b1, ascs_pkg::ADDR_TRIG, 32'h1);
        wait_for(cal_running, 1'b1);
        chk("cal start", 32'h1, {31'h0, cal_running});
        wait_for(cal_running, 1'b0);
        chk("cal length", ascs_pkg::CAL_RUN_CYC, cal_cycles);
        apb(1'b0, ascs_pkg::ADDR_STATUS, 32'h0);
        chk("status", {26'h0, 1'b1, 1'b1, 2'(ascs_pkg::CAL_IDLE), 2'(ascs_pkg::LNK_HALT)},
            r);
    endtask : t_cal
    task automatic t_link();
        apb(1'b1, ascs_pkg::ADDR_CTRL, 32'h7);
        repeat (10) @(posedge pclk);
        chk("link run", 32'h1, {31'h0, link_running});
        chk("no data in sync", 32'h0, {31'h0, link_data_valid});
        sync_grant <= 1'b1;
        wait_for(link_data_valid, 1'b1);
        chk("data state", 32'h1, {31'h0, link_data_valid});
        sync_grant <= 1'b0;
        wait_for(link_data_valid, 1'b0);
        chk("resync", 32'h0, {31'h0, link_data_valid});
        apb(1'b1, ascs_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge pclk);
        chk("link stop", 32'h0, {31'h0, link_running});
    endtask : t_link
    // Main sequence after a ten-cycle reset
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_soft();
        t_cfg();
        t_cal();
        t_link();
        give_verdict();
    end
endmodule : tb_adc_startup_config_sequence
